/* tb/host_bus_model.sv */
`timescale 1ns/1ns
module host_bus_model (
  input  wire logic       mclk,
  output logic            register_window_select,
  output logic [7:0]      host_addr,
  output logic            host_wr,
  output logic            host_rd,
  output logic [7:0]      host_wdata,
  input  wire logic [7:0] host_rdata
);
  initial begin
    register_window_select = 1'b0;
    host_wr                = 1'b0;
    host_rd                = 1'b0;
    host_addr              = 8'h00;
    host_wdata             = 8'h00;
  end

  // one access: held from just after an edge up to the taking edge
  task automatic cyc(input logic sel, input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge mclk);
    #1;
    register_window_select = sel; // host drives the register window select for this access
    host_wr                = w;
    host_rd                = !w;
    host_addr              = a;
    host_wdata             = d;
    @(posedge mclk);
    #1;
    q                      = host_rdata;
    register_window_select = 1'b0;
    host_wr                = 1'b0;
    host_rd                = 1'b0;
    // released bus shows the inverse, not the last value
    host_addr              = ~a;
    host_wdata             = ~d;
  endtask
endmodule // host_bus_model

/* tb/tb_port_macrocell_config_regs.sv */
`timescale 1ns/1ns
`define CHK(n, e, g) do_chk(n, e, g)
module tb_port_macrocell_config_regs;
  import port_macrocell_config_pkg::*;
  localparam logic [7:0] MAIN_INFO = 8'h34;
  localparam logic [7:0] SEC_INFO  = 8'h02;
  logic            mclk, rstn, sel, hwr, hrd, debug_port_on_bit, security_set;
  logic            cell_a_logic_load, cell_b_logic_load;
  logic [7:0]      haddr, hwdata, host_rdata, latched_addr, cell_a_logic_d, cell_b_logic_d, q;
  logic [7:0]      output_cell_group_a_bits, output_cell_group_b_bits, primary_sector_locked;
  logic [7:0]      page_bits, memory_space_placement;
  logic [3:0]      secondary_sector_locked;
  logic [2:0][7:0] input_cell_bits;
  port_bus_t       pin_in, pin_out, pin_oe, pin_fast_slew;
  int              num_errors, check_count;

  port_macrocell_config_regs #(.MAIN_MEM_INFO(MAIN_INFO), .SECOND_MEM_INFO(SEC_INFO),
    .PLACEMENT_RESET(8'h00)) i_dut (
    .mclk(mclk), .rstn(rstn), .register_window_select(sel), .host_addr(haddr),
    .host_wr(hwr), .host_rd(hrd), .host_wdata(hwdata), .host_rdata(host_rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_fast_slew(pin_fast_slew),
    .latched_addr(latched_addr), .input_cell_bits(input_cell_bits),
    .cell_a_logic_d(cell_a_logic_d), .cell_a_logic_load(cell_a_logic_load),
    .cell_b_logic_d(cell_b_logic_d), .cell_b_logic_load(cell_b_logic_load),
    .output_cell_group_a_bits(output_cell_group_a_bits), .output_cell_group_b_bits(output_cell_group_b_bits),
    .primary_sector_locked(primary_sector_locked), .secondary_sector_locked(secondary_sector_locked),
    .security_set(security_set), .debug_port_on_bit(debug_port_on_bit), .page_bits(page_bits),
    .memory_space_placement(memory_space_placement));

  host_bus_model i_host (.mclk(mclk), .register_window_select(sel), .host_addr(haddr), .host_wr(hwr),
    .host_rd(hrd), .host_wdata(hwdata), .host_rdata(host_rdata));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic do_chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host.cyc(1'b1, 1'b1, a, d, q);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    i_host.cyc(1'b1, 1'b0, a, 8'h00, q);
    `CHK($sformatf("read %h", a), e, q);
  endtask
  // register write lands at the taking edge inside wr, before c1; pins follow at c1
  task automatic settle();
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #(50 * 4000);
    num_errors++;
    close_out();
  end

  initial begin
    num_errors = 0;
    check_count = 0;
    rstn = 1'b0;
    pin_in = '0;
    latched_addr = 8'hc3;
    input_cell_bits = {8'h3c, 8'h96, 8'h5a};
    cell_a_logic_d = 8'h00;
    cell_a_logic_load = 1'b0;
    cell_b_logic_d = 8'h00;
    cell_b_logic_load = 1'b0;
    primary_sector_locked = 8'h96;
    secondary_sector_locked = 4'ha;
    security_set = 1'b1;
    repeat (16) @(posedge mclk);
    #1 rstn = 1'b1;
    for (int p = 0; p < NPORT; p++) begin
      rc(PIN_DIR_OFS[p], 8'h00);
      if (HAS_MODE[p]) rc(PIN_MODE_OFS[p], 8'h00);
      rc(PIN_DRIVE_OFS[p], 8'h00);
      `CHK("oe", 8'h00, pin_oe[p]);
      pin_in[p] = 8'(p * 37 + 5);
    end
    rc(8'h22, 8'h00);
    rc(8'he0, 8'h00);
    rc(8'hc7, 8'h00);
    for (int p = 0; p < NPORT; p++) rc(PIN_IN_OFS[p], 8'(p * 37 + 5));
    wr(8'h00, 8'hff);
    rc(8'h00, 8'h05);
    wr(8'h06, 8'hff);
    wr(8'h04, 8'ha5);
    settle();
    `CHK("out a", 8'ha5, pin_out[0]);
    `CHK("oe a", 8'hff, pin_oe[0]);
    rc(8'h0c, 8'hff);
    rc(8'h4c, 8'h00);
    wr(8'h08, 8'hff);
    settle();
    `CHK("oe a od", 8'h5a, pin_oe[0]);
    rc(8'h0c, 8'h5a);
    wr(8'h18, 8'h3c);
    settle();
    `CHK("slew c", 8'h3c, pin_fast_slew[2]);
    `CHK("slew a", 8'h00, pin_fast_slew[0]);
    wr(8'h32, 8'hff);
    settle();
    `CHK("out e", 8'hc3, pin_out[4]);
    `CHK("oe e", 8'hff, pin_oe[4]);
    rc(8'h0a, 8'h5a);
    rc(8'h0b, 8'h96);
    rc(8'h1a, 8'h3c);
    wr(8'h0a, 8'h00);
    rc(8'h0a, 8'h5a);
    wr(8'h22, 8'h0f);
    wr(8'h20, 8'hff);
    rc(8'h20, 8'hf0);
    `CHK("cells a", 8'hf0, output_cell_group_a_bits);
    cell_b_logic_d = 8'h66;
    cell_b_logic_load = 1'b1;
    @(posedge mclk);
    #1 cell_b_logic_load = 1'b0;
    rc(8'h21, 8'h66);
    wr(8'h23, 8'hff);
    wr(8'h21, 8'h00);
    rc(8'h21, 8'h66);
    `CHK("cells b", 8'h66, output_cell_group_b_bits);
    rc(8'hc0, 8'h96);
    rc(8'hc2, 8'h8a);
    security_set = 1'b0;
    rc(8'hc2, 8'h0a);
    wr(8'hc2, 8'hff);
    wr(8'hc0, 8'h00);
    rc(8'hc0, 8'h96);
    rc(8'hc2, 8'h0a);
    wr(8'hc7, 8'hff);
    rc(8'hc7, 8'h01);
    `CHK("debug on", 8'h01, {7'h00, debug_port_on_bit});
    wr(8'he0, 8'h5a);
    rc(8'he0, 8'h5a);
    `CHK("page", 8'h5a, page_bits);
    wr(8'he2, 8'h3c);
    rc(8'he2, 8'h3c);
    `CHK("placement", 8'h3c, memory_space_placement);
    rc(8'hf0, MAIN_INFO);
    rc(8'hf1, SEC_INFO);
    wr(8'hf0, 8'hff);
    rc(8'hf0, MAIN_INFO);
    i_host.cyc(1'b0, 1'b1, 8'he0, 8'h00, q);
    rc(8'he0, 8'h5a);
    rc(8'h1b, 8'h00);
    rstn = 1'b0;
    @(posedge mclk);
    #1;
    `CHK("page rst", 8'h00, page_bits);
    `CHK("debug rst", 8'h00, {7'h00, debug_port_on_bit});
    rstn = 1'b1;
    rc(8'he2, 8'h00);
    close_out();
  end
endmodule // tb_port_macrocell_config_regs

/* verilog/port_macrocell_config_pkg.sv */
package port_macrocell_config_pkg;
  localparam int NPORT = 7;
  localparam int PW    = 8;

  typedef logic [NPORT-1:0][PW-1:0] port_bus_t;
  typedef logic [NPORT-1:0][7:0]    ofs_tab_t;

  // port index 0..6 is port A..G
  localparam logic [2:0] PORT_A = 3'd0;
  localparam logic [2:0] PORT_C = 3'd2;
  localparam logic [2:0] PORT_E = 3'd4;

  localparam ofs_tab_t PIN_IN_OFS    = {8'h41, 8'h40, 8'h30, 8'h11, 8'h10, 8'h01, 8'h00};
  localparam ofs_tab_t PIN_MODE_OFS  = {8'h43, 8'h42, 8'h32, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam ofs_tab_t PIN_OUT_OFS   = {8'h45, 8'h44, 8'h34, 8'h15, 8'h14, 8'h05, 8'h04};
  localparam ofs_tab_t PIN_DIR_OFS   = {8'h47, 8'h46, 8'h36, 8'h17, 8'h16, 8'h07, 8'h06};
  localparam ofs_tab_t PIN_DRIVE_OFS = {8'h49, 8'h48, 8'h38, 8'h19, 8'h18, 8'h09, 8'h08};
  localparam ofs_tab_t PIN_OE_OFS    = {8'h00, 8'h4c, 8'h00, 8'h00, 8'h1c, 8'h0d, 8'h0c};
  localparam ofs_tab_t IN_CELL_OFS   = {8'h00, 8'h00, 8'h00, 8'h00, 8'h1a, 8'h0b, 8'h0a};

  // which ports carry each register
  localparam logic [NPORT-1:0] HAS_MODE    = 7'b1110000;
  localparam logic [NPORT-1:0] HAS_SLEW    = 7'b0100100;
  localparam logic [NPORT-1:0] HAS_OE_STAT = 7'b0100111;
  localparam logic [NPORT-1:0] HAS_IN_CELL = 7'b0000111;

  localparam logic [7:0] OUT_CELL_A_OFS   = 8'h20;
  localparam logic [7:0] OUT_CELL_B_OFS   = 8'h21;
  localparam logic [7:0] CELL_A_BLOCK_OFS = 8'h22;
  localparam logic [7:0] CELL_B_BLOCK_OFS = 8'h23;
  localparam logic [7:0] PRIMARY_LOCK_OFS = 8'hc0;
  localparam logic [7:0] SECOND_LOCK_OFS  = 8'hc2;
  localparam logic [7:0] DEBUG_EN_OFS     = 8'hc7;
  localparam logic [7:0] PAGE_SELECT_OFS  = 8'he0;
  localparam logic [7:0] PLACEMENT_OFS    = 8'he2;
  localparam logic [7:0] MAIN_MEM_OFS     = 8'hf0;
  localparam logic [7:0] SECOND_MEM_OFS   = 8'hf1;

  localparam int SECURITY_BIT = 7;
  localparam int DEBUG_ON_BIT = 0;

  localparam logic [7:0] PORT_RESET  = 8'h00;
  localparam logic [7:0] PAGE_RESET  = 8'h00;
  localparam logic [7:0] DEBUG_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;
endpackage

/* verilog/port_macrocell_config_regs.sv */
`timescale 1ns/1ns
// Contract
// - pin-input register is read-only and returns the live pin levels
// - pin-output register holds host value, driven onto pins in output mode
// - direction bit 0 input, 1 output; all bits reset to 0
// - ports E,F,G mode bit 0 general I/O, 1 latched address out
// - ports A,B,D,E,G drive bit 0 push-pull, 1 open-drain
// - ports C,F drive bit 0 push-pull, 1 fast slew
// - ports A,B,C,F read-only status: 1 driver enabled, 0 tri-stated
// - read-only input cell states for ports A, B and C
// - output cell write loads flip-flops; read returns cell outputs
// - block bit 1 stops host load of that output cell, 0 allows
// - read-only primary lock register, one bit per eight sectors
// - secondary lock bits 3..0 per sector, bits 6..4 read zero
// - secondary lock bit 7 reads security bit state
// - debug-port enable bit 0, bits 7..1 unused
// - read-only f0 reports main flash and sram size
// - registers sit in a 256-byte window offset from host-placed base
// - page register drives page inputs to logic, resets to zero
module port_macrocell_config_regs #(
  parameter logic [7:0] MAIN_MEM_INFO   = 8'h34,
  parameter logic [7:0] SECOND_MEM_INFO = 8'h02,
  parameter logic [7:0] PLACEMENT_RESET = 8'h00
) (
  input  wire logic                                  mclk,
  input  wire logic                                  rstn,
  input  wire logic                                  register_window_select,
  input  wire logic [7:0]                            host_addr,
  input  wire logic                                  host_wr,
  input  wire logic                                  host_rd,
  input  wire logic [7:0]                            host_wdata,
  output logic      [7:0]                            host_rdata,
  input  wire port_macrocell_config_pkg::port_bus_t  pin_in,
  output port_macrocell_config_pkg::port_bus_t       pin_out,
  output port_macrocell_config_pkg::port_bus_t       pin_oe,
  output port_macrocell_config_pkg::port_bus_t       pin_fast_slew,
  input  wire logic [7:0]                            latched_addr,
  input  wire logic [2:0][7:0]                       input_cell_bits,
  input  wire logic [7:0]                            cell_a_logic_d,
  input  wire logic                                  cell_a_logic_load,
  input  wire logic [7:0]                            cell_b_logic_d,
  input  wire logic                                  cell_b_logic_load,
  output logic      [7:0]                            output_cell_group_a_bits,
  output logic      [7:0]                            output_cell_group_b_bits,
  input  wire logic [7:0]                            primary_sector_locked,
  input  wire logic [3:0]                            secondary_sector_locked,
  input  wire logic                                  security_set,
  output logic                                       debug_port_on_bit,
  output logic      [7:0]                            page_bits,
  output logic      [7:0]                            memory_space_placement
);
  import port_macrocell_config_pkg::*;

  port_bus_t  pin_output_latch_q;
  port_bus_t  pin_direction_q;
  port_bus_t  pin_mode_select_q;
  port_bus_t  pin_drive_q;
  port_bus_t  pin_out_d;
  port_bus_t  pin_oe_d;
  logic [7:0] cell_a_block_q;
  logic [7:0] cell_b_block_q;
  logic [7:0] debug_port_enable_q;
  logic [7:0] rdata_d;
  logic       wr_en;
  logic       rd_en;

  // window select qualifies every access; offset is the low address byte
  assign wr_en = register_window_select & host_wr;
  assign rd_en = register_window_select & host_rd;

  genvar p;
  generate
    for (p = 0; p < NPORT; p++) begin : g_port
      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          pin_output_latch_q[p] <= PORT_RESET;
        end else if (wr_en && host_addr == PIN_OUT_OFS[p]) begin
          pin_output_latch_q[p] <= host_wdata;
        end
      end

      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          pin_direction_q[p] <= PORT_RESET;
        end else if (wr_en && host_addr == PIN_DIR_OFS[p]) begin
          pin_direction_q[p] <= host_wdata;
        end
      end

      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          pin_mode_select_q[p] <= PORT_RESET;
        end else if (HAS_MODE[p] && wr_en && host_addr == PIN_MODE_OFS[p]) begin
          pin_mode_select_q[p] <= host_wdata;
        end
      end

      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          pin_drive_q[p] <= PORT_RESET;
        end else if (wr_en && host_addr == PIN_DRIVE_OFS[p]) begin
          pin_drive_q[p] <= host_wdata;
        end
      end

      // per pin: address-out overrides general I/O; open-drain releases on a one
      always_comb begin
        pin_out_d[p] = pin_mode_select_q[p] & latched_addr | ~pin_mode_select_q[p] & pin_output_latch_q[p];
        pin_oe_d[p]  = pin_mode_select_q[p] | pin_direction_q[p];
        if (!HAS_SLEW[p]) begin
          pin_oe_d[p] = pin_oe_d[p] & ~(pin_drive_q[p] & pin_out_d[p]);
        end
      end

      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          pin_out[p]       <= PORT_RESET;
          pin_oe[p]        <= PORT_RESET;
          pin_fast_slew[p] <= PORT_RESET;
        end else begin
          pin_out[p]       <= pin_out_d[p];
          pin_oe[p]        <= pin_oe_d[p];
          pin_fast_slew[p] <= HAS_SLEW[p] ? pin_drive_q[p] : PORT_RESET;
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cell_a_block_q <= PORT_RESET;
      cell_b_block_q <= PORT_RESET;
    end else if (wr_en) begin
      if (host_addr == CELL_A_BLOCK_OFS) begin
        cell_a_block_q <= host_wdata;
      end
      if (host_addr == CELL_B_BLOCK_OFS) begin
        cell_b_block_q <= host_wdata;
      end
    end
  end

  // a host write wins over the logic array's own load for every bit; blocked bits keep their value
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      output_cell_group_a_bits <= PORT_RESET;
    end else if (wr_en && host_addr == OUT_CELL_A_OFS) begin
      output_cell_group_a_bits <= cell_a_block_q & output_cell_group_a_bits
                                | ~cell_a_block_q & host_wdata;
    end else if (cell_a_logic_load) begin
      output_cell_group_a_bits <= cell_a_logic_d;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      output_cell_group_b_bits <= PORT_RESET;
    end else if (wr_en && host_addr == OUT_CELL_B_OFS) begin
      output_cell_group_b_bits <= cell_b_block_q & output_cell_group_b_bits
                                | ~cell_b_block_q & host_wdata;
    end else if (cell_b_logic_load) begin
      output_cell_group_b_bits <= cell_b_logic_d;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      debug_port_enable_q <= DEBUG_RESET;
    end else if (wr_en && host_addr == DEBUG_EN_OFS) begin
      debug_port_enable_q <= {7'h00, host_wdata[DEBUG_ON_BIT]};
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      debug_port_on_bit <= 1'b0;
    end else begin
      debug_port_on_bit <= debug_port_enable_q[DEBUG_ON_BIT];
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      page_bits <= PAGE_RESET;
    end else if (wr_en && host_addr == PAGE_SELECT_OFS) begin
      page_bits <= host_wdata;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      memory_space_placement <= PLACEMENT_RESET;
    end else if (wr_en && host_addr == PLACEMENT_OFS) begin
      memory_space_placement <= host_wdata;
    end
  end

  // read-only registers have no write path at all
  always_comb begin
    rdata_d = UNMAPPED_RD;
    for (int i = 0; i < NPORT; i++) begin
      if (host_addr == PIN_IN_OFS[i]) begin
        rdata_d = pin_in[i];
      end
      if (host_addr == PIN_OUT_OFS[i]) begin
        rdata_d = pin_output_latch_q[i];
      end
      if (host_addr == PIN_DIR_OFS[i]) begin
        rdata_d = pin_direction_q[i];
      end
      if (HAS_MODE[i] && host_addr == PIN_MODE_OFS[i]) begin
        rdata_d = pin_mode_select_q[i];
      end
      if (host_addr == PIN_DRIVE_OFS[i]) begin
        rdata_d = pin_drive_q[i];
      end
      if (HAS_OE_STAT[i] && host_addr == PIN_OE_OFS[i]) begin
        rdata_d = pin_oe[i];
      end
      if (HAS_IN_CELL[i] && host_addr == IN_CELL_OFS[i]) begin
        rdata_d = input_cell_bits[i];
      end
    end
    unique case (host_addr)
      OUT_CELL_A_OFS:   rdata_d = output_cell_group_a_bits;
      OUT_CELL_B_OFS:   rdata_d = output_cell_group_b_bits;
      CELL_A_BLOCK_OFS: rdata_d = cell_a_block_q;
      CELL_B_BLOCK_OFS: rdata_d = cell_b_block_q;
      PRIMARY_LOCK_OFS: rdata_d = primary_sector_locked;
      SECOND_LOCK_OFS:  rdata_d = {security_set, 3'h0, secondary_sector_locked};
      DEBUG_EN_OFS:     rdata_d = debug_port_enable_q;
      PAGE_SELECT_OFS:  rdata_d = page_bits;
      PLACEMENT_OFS:    rdata_d = memory_space_placement;
      MAIN_MEM_OFS:     rdata_d = MAIN_MEM_INFO;
      SECOND_MEM_OFS:   rdata_d = SECOND_MEM_INFO;
      default: ;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      host_rdata <= UNMAPPED_RD;
    end else if (rd_en) begin
      host_rdata <= rdata_d;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence s_wr(logic [7:0] a);
    wr_en && host_addr == a;
  endsequence
  sequence s_rd(logic [7:0] a);
    rd_en && host_addr == a;
  endsequence
  sequence s_wr_rd(logic [7:0] a);
    s_wr(a) ##1 !wr_en ##1 s_rd(a);
  endsequence

  a_pin_in_read: assert property (s_rd(PIN_IN_OFS[0]) |=> host_rdata == $past(pin_in[0]))
    else $error("pin input read mismatch");
  a_out_drive: assert property (s_wr(PIN_OUT_OFS[0])
                                ##1 (pin_direction_q[0] == 8'hff && pin_drive_q[0] == 8'h00)
                                |=> pin_out[0] == $past(pin_output_latch_q[0]) && pin_oe[0] == 8'hff)
    else $error("output latch not driven");
  a_dir_write: assert property (s_wr(PIN_DIR_OFS[0]) |=> pin_direction_q[0] == $past(host_wdata))
    else $error("direction write lost");
  a_addr_mode: assert property (pin_mode_select_q[PORT_E][0] && !pin_drive_q[PORT_E][0]
                                |=> pin_out[PORT_E][0] == $past(latched_addr[0]) && pin_oe[PORT_E][0])
    else $error("address out not driven");
  a_open_drain: assert property (pin_drive_q[0][0] && pin_out_d[0][0] |=> !pin_oe[0][0])
    else $error("open drain drives high");
  a_slew_follow: assert property (##1 pin_fast_slew[PORT_C] == $past(pin_drive_q[PORT_C]))
    else $error("slew select wrong");
  a_oe_status: assert property (s_rd(PIN_OE_OFS[0]) |=> host_rdata == $past(pin_oe[0]))
    else $error("enable status wrong");
  a_cell_in_read: assert property (s_rd(IN_CELL_OFS[PORT_C]) |=> host_rdata == $past(input_cell_bits[2]))
    else $error("input cell read wrong");
  a_cell_block: assert property (s_wr(OUT_CELL_A_OFS) |=>
                                 (output_cell_group_a_bits & $past(cell_a_block_q))
                                 == ($past(output_cell_group_a_bits) & $past(cell_a_block_q))
                                 && (output_cell_group_a_bits & ~$past(cell_a_block_q))
                                 == ($past(host_wdata) & ~$past(cell_a_block_q)))
    else $error("cell load ignores block");
  a_second_lock: assert property (s_rd(SECOND_LOCK_OFS) |=>
                                  host_rdata == {$past(security_set), 3'h0, $past(secondary_sector_locked)})
    else $error("secondary lock read wrong");
  a_debug_bit: assert property (s_wr(DEBUG_EN_OFS) |-> ##2 debug_port_on_bit == $past(host_wdata[0], 2))
    else $error("debug enable wrong");
  a_page_feed: assert property (s_wr(PAGE_SELECT_OFS) |=> page_bits == $past(host_wdata))
    else $error("page write lost");
  a_dir_input: assert property (pin_direction_q[0] == 8'h00 |=> pin_oe[0] == 8'h00)
    else $error("input pin driven");
  a_push_pull: assert property (pin_direction_q[0][0] && !pin_drive_q[0][0] |=> pin_oe[0][0])
    else $error("push pull not driven");
  a_io_mode: assert property (!pin_mode_select_q[PORT_E][0] && !pin_drive_q[PORT_E][0] |=>
                              pin_out[PORT_E][0] == $past(pin_output_latch_q[PORT_E][0])
                              && pin_oe[PORT_E][0] == $past(pin_direction_q[PORT_E][0]))
    else $error("general io mode wrong");
  a_ro_write: assert property (s_wr(PIN_IN_OFS[0]) |=>
                               $stable(pin_mode_select_q) && $stable(pin_output_latch_q)
                               && $stable(pin_direction_q) && $stable(pin_drive_q))
    else $error("read-only write changed state");
  a_pin_in_c: assert property (s_rd(PIN_IN_OFS[PORT_C]) |=> host_rdata == $past(pin_in[2]))
    else $error("port c input read wrong");
  a_cell_in_a: assert property (s_rd(IN_CELL_OFS[PORT_A]) |=> host_rdata == $past(input_cell_bits[0]))
    else $error("input cell a read wrong");
  a_cell_in_b: assert property (s_rd(IN_CELL_OFS[1]) |=> host_rdata == $past(input_cell_bits[1]))
    else $error("input cell b read wrong");
  a_oe_port_f: assert property (s_rd(PIN_OE_OFS[5]) |=> host_rdata == $past(pin_oe[5]))
    else $error("port f enable status wrong");
  a_primary_lock: assert property (s_rd(PRIMARY_LOCK_OFS) |=> host_rdata == $past(primary_sector_locked))
    else $error("primary lock read wrong");
  a_main_info: assert property (s_rd(MAIN_MEM_OFS) |=> host_rdata == MAIN_MEM_INFO)
    else $error("main memory info wrong");
  a_second_info: assert property (s_rd(SECOND_MEM_OFS) |=> host_rdata == SECOND_MEM_INFO)
    else $error("secondary memory info wrong");
  a_place_write: assert property (s_wr(PLACEMENT_OFS) |=> memory_space_placement == $past(host_wdata))
    else $error("placement write lost");
  a_wr_gate: assert property (!register_window_select |=>
                              $stable(page_bits) && $stable(memory_space_placement)
                              && $stable(debug_port_enable_q) && $stable(cell_a_block_q))
    else $error("write outside window landed");
  a_rd_hold: assert property (!rd_en |=> $stable(host_rdata))
    else $error("read data not held");
  a_logic_load: assert property (cell_b_logic_load && !(wr_en && host_addr == OUT_CELL_B_OFS) |=>
                                 output_cell_group_b_bits == $past(cell_b_logic_d))
    else $error("logic load lost");
  a_block_b: assert property (s_wr(OUT_CELL_B_OFS) |=>
                              (output_cell_group_b_bits & $past(cell_b_block_q))
                              == ($past(output_cell_group_b_bits) & $past(cell_b_block_q))
                              && (output_cell_group_b_bits & ~$past(cell_b_block_q))
                              == ($past(host_wdata) & ~$past(cell_b_block_q)))
    else $error("cell b load ignores block");
  a_debug_store: assert property (s_wr(DEBUG_EN_OFS) |=> debug_port_enable_q[7:1] == 7'h00)
    else $error("debug unused bits stored");
  a_page_readback: assert property (s_wr_rd(PAGE_SELECT_OFS) |=> host_rdata == $past(host_wdata, 3))
    else $error("page readback wrong");
  a_place_readback: assert property (s_wr_rd(PLACEMENT_OFS) |=> host_rdata == $past(host_wdata, 3))
    else $error("placement readback wrong");
  a_ro_main: assert property (s_wr_rd(MAIN_MEM_OFS) |=> host_rdata == MAIN_MEM_INFO)
    else $error("main memory info overwritten");
  a_ro_primary: assert property (s_wr_rd(PRIMARY_LOCK_OFS) |=> host_rdata == $past(primary_sector_locked))
    else $error("primary lock overwritten");
  a_debug_readback: assert property (s_wr_rd(DEBUG_EN_OFS) |=>
                                     host_rdata == {7'h00, $past(host_wdata[DEBUG_ON_BIT], 3)})
    else $error("debug readback wrong");
endmodule // port_macrocell_config_regs
